// ### rtl/sfspi_pkg.sv
// package: constants and types of the serial flash bus front end
package sfspi_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned PUW_US  = 10;
	localparam int unsigned PUW_CYC = PUW_US * CLK_MHZ;
	localparam int unsigned OP_CYC  = 200;
	localparam int unsigned CNT_W   = 24;
	localparam int unsigned ADDR_W  = 22;

	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR  = 8'h01;
	localparam logic [7:0] OP_PP    = 8'h02;
	localparam logic [7:0] OP_SE    = 8'h20;
	localparam logic [7:0] OP_BE32  = 8'h52;
	localparam logic [7:0] OP_BE64  = 8'hd8;
	localparam logic [7:0] OP_CE1   = 8'hc7;
	localparam logic [7:0] OP_CE2   = 8'h60;
	localparam logic [7:0] OP_PD    = 8'hb9;
	localparam logic [7:0] OP_RPD   = 8'hab;
	localparam logic [7:0] OP_SUSP  = 8'h75;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_DOUT  = 8'h3b;
	localparam logic [7:0] OP_DIO   = 8'hbb;
	localparam logic [7:0] OP_QOUT  = 8'h6b;
	localparam logic [7:0] OP_QIO   = 8'heb;

	// low status byte: busy, write latch, range code, bottom, small unit, lock lo
	localparam int ST_WL    = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 4;
	localparam int ST_LKLO  = 7;
	localparam int ST_SEC   = 6;
	localparam int ST_TB    = 5;
	// high status byte: lock hi at bit 0, quad lane enable at bit 1
	localparam int SH_LKHI  = 0;
	localparam int SH_QE    = 1;
	localparam int LANE_WP   = 2;
	localparam int LANE_HOLD = 3;

	localparam logic [2:0] W1      = 3'h1;
	localparam logic [2:0] W2      = 3'h2;
	localparam logic [2:0] W4      = 3'h4;
	localparam logic [3:0] OE_1    = 4'h2;
	localparam logic [3:0] OE_2    = 4'h3;
	localparam logic [3:0] OE_4    = 4'hf;
	localparam logic [5:0] CLK_BYTE = 6'h08;
	localparam logic [5:0] CLK_A1  = 6'h18;
	localparam logic [5:0] CLK_A2  = 6'h10;
	localparam logic [5:0] CLK_A4  = 6'h08;
	localparam logic [3:0] DMY_8   = 4'h8;
	localparam logic [3:0] DMY_4   = 4'h4;
	localparam logic [4:0] SH_4K   = 5'h0c;
	localparam logic [4:0] SH_64K  = 5'h10;
	localparam logic [2:0] SEC_CAP = 3'h4;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL  = 3'h7;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_CMD   = 7'h02,
		ST_ADDR  = 7'h04,
		ST_DUMMY = 7'h08,
		ST_DIN   = 7'h10,
		ST_DOUT  = 7'h20,
		ST_SKIP  = 7'h40
	} sfspi_state_type;

	typedef struct packed {
		logic       ok;
		logic [5:0] a_clk;
		logic [2:0] a_w;
		logic       mode;
		logic [3:0] dmy;
		logic [2:0] o_w;
	} sfspi_dec_type;
endpackage

// ### rtl/sfspi_front_end.sv
// module: serial flash bus front end with pause, write gating and status protection
`timescale 1ns/1ps
module sfspi_front_end #(
	parameter int unsigned PUW_CYCLES = sfspi_pkg::PUW_CYC,
	parameter int unsigned OP_CYCLES  = sfspi_pkg::OP_CYC,
	parameter int unsigned ADDR_BITS  = sfspi_pkg::ADDR_W
) (
	input  logic        clk_sys_i,
	input  logic        rst_n_i,
	input  logic        cs_n_i,
	input  logic        sclk_i,
	input  logic [3:0]  lane_i,
	output logic [3:0]  lane_o,
	output logic [3:0]  lane_oe_o,
	output logic [23:0] addr_o,
	input  logic [7:0]  array_data_i,
	output logic [7:0]  wdata_o,
	output logic        wdata_valid_o,
	output logic        op_start_o,
	output logic [7:0]  op_code_o,
	output logic        busy_o
);
	import sfspi_pkg::*;

	typedef struct packed {
		logic [1:0]       cs_q, ck_q, nbyte, new_hi;
		logic [3:0]       ln_m, ln_s, obits, lane, oe;
		logic             cs_d, ck_d, paused, pd, busy, write_latch, puw_done, lk_hi, qe, wvalid, start;
		sfspi_state_type  st;
		logic [7:0]       op, obuf, st_lo, new_lo, wdata;
		logic [31:0]      sr;
		logic [5:0]       cnt;
		logic [23:0]      addr;
		logic [CNT_W-1:0] opcnt, puwcnt;
	} sfspi_regs_type;

	sfspi_regs_type r;
	sfspi_regs_type n;

	function automatic sfspi_dec_type decode(input logic [7:0] op);
		decode = '0;
		decode.ok = 1'b1;
		decode.a_w = W1;
		case (op)
			OP_READ: begin
				decode.a_clk = CLK_A1;
				decode.o_w = W1;
			end
			OP_FREAD, OP_DOUT, OP_QOUT: begin
				decode.a_clk = CLK_A1;
				decode.dmy = DMY_8;
				decode.o_w = (op == OP_FREAD) ? W1 : (op == OP_DOUT) ? W2 : W4;
			end
			OP_DIO: begin
				decode.a_clk = CLK_A2;
				decode.a_w = W2;
				decode.mode = 1'b1;
				decode.o_w = W2;
			end
			OP_QIO: begin
				decode.a_clk = CLK_A4;
				decode.a_w = W4;
				decode.mode = 1'b1;
				decode.dmy = DMY_4;
				decode.o_w = W4;
			end
			OP_PP, OP_SE, OP_BE32, OP_BE64: decode.a_clk = CLK_A1;
			OP_RDSR1, OP_RDSR2: decode.o_w = W1;
			OP_WREN, OP_WRDI, OP_WRSR, OP_CE1, OP_CE2, OP_PD, OP_RPD, OP_SUSP: decode.ok = 1'b1;
			default: decode.ok = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] shin(input logic [31:0] sr, input logic [3:0] l, input logic [2:0] w);
		case (w)
			W1: shin = {sr[30:0], l[0]};
			W2: shin = {sr[29:0], l[1:0]};
			default: shin = {sr[27:0], l};
		endcase
	endfunction

	// the start address alone is checked; with the small unit bit a block erase can straddle a range edge
	function automatic logic prot_hit(input logic [23:0] a, input logic [7:0] s);
		logic [2:0]  bp;
		logic [4:0]  sh;
		logic [24:0] sz, am, asz;
		bp = s[ST_BP_HI:ST_BP_LO];
		sh = s[ST_SEC] ? SH_4K + {2'h0, ((bp > SEC_CAP) ? SEC_CAP : bp) - 3'h1} : SH_64K + {2'h0, bp - 3'h1};
		sz = 25'h1 << sh;
		asz = 25'h1 << ADDR_BITS;
		am = {1'b0, a} & (asz - 25'h1);
		if (bp == BP_NONE)
			prot_hit = 1'b0;
		else if (bp == BP_ALL || sz >= asz)
			prot_hit = 1'b1;
		else if (s[ST_TB])
			prot_hit = am < sz;
		else
			prot_hit = am >= asz - sz;
	endfunction

	always_comb begin
		logic          sel, rise, fall, quad_now, locked, wok, go;
		logic [2:0]    w;
		logic [7:0]    b;
		logic [31:0]   nsr;
		sfspi_dec_type dec, d;
		n = r;
		n.start = 1'b0;
		n.wvalid = 1'b0;
		n.cs_q = {r.cs_q[0], cs_n_i};
		n.ck_q = {r.ck_q[0], sclk_i};
		n.ln_m = lane_i;
		n.ln_s = r.ln_m;
		n.cs_d = r.cs_q[1];
		n.ck_d = r.ck_q[1];
		sel = !r.cs_q[1];
		// edges alone matter, so idle clock level at select (mode 0 or 3) is irrelevant
		rise = sel && r.ck_q[1] && !r.ck_d && !r.paused;
		fall = sel && !r.ck_q[1] && r.ck_d && !r.paused;
		dec = decode(r.op);
		d = '0;
		quad_now = r.st != ST_IDLE && r.st != ST_CMD && dec.o_w == W4;
		// with quad enable the protect pin is a data lane and loses its lock role
		locked = r.lk_hi || (r.st_lo[ST_LKLO] && !r.qe && !r.ln_s[LANE_WP]);
		wok = r.puw_done && !r.busy && !r.pd && r.write_latch;
		go = 1'b0;
		w = dec.o_w;
		b = r.obuf;
		nsr = r.sr;

		if (!r.puw_done) begin
			n.puwcnt = r.puwcnt + 1'b1;
			n.puw_done = r.puwcnt == CNT_W'(PUW_CYCLES - 1);
		end
		if (r.busy) begin
			n.opcnt = r.opcnt + 1'b1;
			if (r.opcnt == CNT_W'(OP_CYCLES - 1)) begin
				n.busy = 1'b0;
				n.write_latch = 1'b0;
			end
		end

		// clock low makes the pause follow the pin; clock high waits for its fall
		if (!sel || r.qe || quad_now)
			n.paused = 1'b0;
		else if (!r.ck_q[1])
			n.paused = !r.ln_s[LANE_HOLD];

		if (!sel) begin
			n.st = ST_IDLE;
			n.oe = 4'h0;
			if (!r.cs_d && r.st == ST_DIN) begin
				case (r.op)
					OP_WREN: n.write_latch = r.puw_done && !r.busy && !r.pd;
					OP_WRDI: n.write_latch = 1'b0;
					OP_WRSR: go = wok && !locked && r.nbyte != 2'h0;
					OP_PP, OP_SE, OP_BE32, OP_BE64: go = wok && !prot_hit(r.addr, r.st_lo);
					OP_CE1, OP_CE2: go = wok && r.st_lo[ST_BP_HI:ST_BP_LO] == BP_NONE;
					OP_PD: n.pd = 1'b1;
					OP_RPD: n.pd = 1'b0;
					default: go = 1'b0;
				endcase
				if (go) begin
					n.busy = 1'b1;
					n.opcnt = '0;
					n.start = 1'b1;
				end
				if (go && r.op == OP_WRSR) begin
					n.st_lo[ST_LKLO:ST_BP_LO] = r.new_lo[ST_LKLO:ST_BP_LO];
					if (r.nbyte != 2'h1) begin
						n.lk_hi = r.new_hi[SH_LKHI];
						n.qe = r.new_hi[SH_QE];
					end
				end
			end
		end else if (r.cs_d) begin
			// a select fall is the only way out of idle
			n.st = ST_CMD;
			n.cnt = CLK_BYTE;
			n.nbyte = 2'h0;
			n.obits = 4'h0;
		end else begin
			if (rise) begin
				case (r.st)
					ST_CMD: begin
						nsr = shin(r.sr, r.ln_s, W1);
						n.sr = nsr;
						n.cnt = r.cnt - 6'h1;
						if (r.cnt == 6'h1) begin
							n.op = nsr[7:0];
							d = decode(nsr[7:0]);
							if (!d.ok || (r.pd && nsr[7:0] != OP_RPD))
								n.st = ST_SKIP;
							else if (r.busy && nsr[7:0] != OP_RDSR1 && nsr[7:0] != OP_RDSR2 && nsr[7:0] != OP_SUSP)
								n.st = ST_SKIP;
							else if (d.o_w == W4 && !r.qe)
								n.st = ST_SKIP;
							else if (d.a_clk != 6'h0) begin
								n.st = ST_ADDR;
								n.cnt = d.a_clk;
							end else begin
								n.st = (d.o_w != 3'h0) ? ST_DOUT : ST_DIN;
								n.cnt = CLK_BYTE;
							end
						end
					end
					ST_ADDR: begin
						nsr = shin(r.sr, r.ln_s, dec.a_w);
						n.sr = nsr;
						n.cnt = r.cnt - 6'h1;
						if (r.cnt == 6'h1) begin
							n.addr = dec.mode ? nsr[31:8] : nsr[23:0];
							if (dec.dmy != 4'h0) begin
								n.st = ST_DUMMY;
								n.cnt = {2'h0, dec.dmy};
							end else begin
								n.st = (dec.o_w != 3'h0) ? ST_DOUT : ST_DIN;
								n.cnt = CLK_BYTE;
							end
						end
					end
					ST_DUMMY: begin
						n.cnt = r.cnt - 6'h1;
						if (r.cnt == 6'h1)
							n.st = ST_DOUT;
					end
					ST_DIN: begin
						nsr = shin(r.sr, r.ln_s, W1);
						n.sr = nsr;
						n.cnt = r.cnt - 6'h1;
						if (r.cnt == 6'h1) begin
							n.cnt = CLK_BYTE;
							n.nbyte = (r.nbyte == 2'h3) ? r.nbyte : r.nbyte + 2'h1;
							if (r.nbyte == 2'h0)
								n.new_lo = nsr[7:0];
							if (r.nbyte == 2'h1)
								n.new_hi = nsr[1:0];
							if (r.op == OP_PP) begin
								n.wdata = nsr[7:0];
								n.wvalid = wok && !prot_hit(r.addr, r.st_lo);
							end
						end
					end
					default: n.st = r.st;
				endcase
			end
			if (fall && r.st == ST_DOUT) begin
				if (r.obits == 4'h0) begin
					if (r.op == OP_RDSR1)
						b = {r.st_lo[ST_LKLO:ST_BP_LO], r.write_latch, r.busy};
					else if (r.op == OP_RDSR2)
						b = {6'h0, r.qe, r.lk_hi};
					else begin
						b = array_data_i;
						n.addr = r.addr + 24'h1;
					end
					n.obits = 4'h8 - {1'b0, w};
				end else
					n.obits = r.obits - {1'b0, w};
				n.obuf = b << w;
				case (w)
					W1: n.lane = {2'h0, b[7], 1'b0};
					W2: n.lane = {2'h0, b[7:6]};
					default: n.lane = b[7:4];
				endcase
				n.oe = (w == W1) ? OE_1 : (w == W2) ? OE_2 : OE_4;
			end
		end

		if (!rst_n_i) begin
			// power-on: every register but the state, which loads ST_IDLE, clears, range code included, and the power-cycle lock mode falls back to 0,0
			n = '0;
			n.st = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		r <= n;
	end

	assign lane_o        = r.lane;
	assign lane_oe_o     = r.oe & {4{!r.paused}};
	assign addr_o        = r.addr;
	assign wdata_o       = r.wdata;
	assign wdata_valid_o = r.wvalid;
	assign op_start_o    = r.start;
	assign op_code_o     = r.op;
	assign busy_o        = r.busy;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_desel_float;
		r.cs_q[1] && r.cs_d |-> lane_oe_o == 4'h0;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("outputs driven while deselected");
	// a pause mid-frame must keep the frame position so the transfer resumes
	property p_pause_float;
		r.paused && !r.cs_q[1] && !r.cs_d |->
			lane_oe_o == 4'h0 ##1 ($stable(r.st) && $stable(r.sr) && $stable(r.cnt));
	endproperty
	a_pause_float: assert property (p_pause_float) else $error("output driven while paused");
	property p_wel_done;
		$fell(r.busy) |-> !r.write_latch && $past(r.write_latch, 2);
	endproperty
	a_wel_done: assert property (p_wel_done) else $error("write latch not cleared at completion");
	property p_puw;
		!r.puw_done |-> !r.write_latch && !r.busy;
	endproperty
	a_puw: assert property (p_puw) else $error("write accepted before power-up delay");
	property p_busy_cause;
		$rose(r.busy) |-> $past(r.write_latch) && !$past(r.pd) && op_start_o;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy set without write latch");
	property p_lock;
		$rose(r.busy) && r.op == OP_WRSR |-> !$past(r.lk_hi);
	endproperty
	a_lock: assert property (p_lock) else $error("status write while locked");
	property p_no_quad_pause;
		r.st == ST_DOUT && (r.op == OP_QOUT || r.op == OP_QIO) |-> !r.paused;
	endproperty
	a_no_quad_pause: assert property (p_no_quad_pause) else $error("pause during quad transfer");
	property p_single_out;
		r.st == ST_DOUT && r.op == OP_RDSR1 && lane_oe_o != 4'h0 |-> lane_oe_o == OE_1;
	endproperty
	a_single_out: assert property (p_single_out) else $error("status not on single lane");
	property p_quad_out;
		r.st == ST_DOUT && (r.op == OP_QOUT || r.op == OP_QIO) && lane_oe_o != 4'h0 |-> lane_oe_o == OE_4 && r.qe;
	endproperty
	a_quad_out: assert property (p_quad_out) else $error("quad read without quad enable");
	property p_ce_prot;
		$rose(r.busy) && (r.op == OP_CE1 || r.op == OP_CE2) |-> $past(r.st_lo[ST_BP_HI:ST_BP_LO]) == BP_NONE;
	endproperty
	a_ce_prot: assert property (p_ce_prot) else $error("chip erase over protected range");

	c_status_read: cover property (r.st == ST_DOUT && r.op == OP_RDSR1 && lane_oe_o == OE_1);
	c_quad_read: cover property (r.st == ST_DOUT && (r.op == OP_QOUT || r.op == OP_QIO) && lane_oe_o == OE_4);
	c_pause: cover property ($rose(r.paused) ##[1:200] $fell(r.paused));
	c_program: cover property ($rose(r.busy) && r.op == OP_PP);
endmodule // sfspi_front_end

// ### tb/sfspi_spi_master.sv
// bus master model: drives select, serial clock, data lane 0, protect and pause pins
`timescale 1ns/1ps
module sfspi_spi_master #(
	parameter int HALF = 8
) (
	input  logic       clk_sys_i,
	input  logic [3:0] dev_i,
	input  logic [3:0] dev_oe_i,
	output logic       cs_n_o,
	output logic       sclk_o,
	output logic [3:0] pins_o
);
	logic mode3;
	logic d0;
	logic wp;
	logic hold;

	initial begin
		mode3 = 1'b0;
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		d0 = 1'b0;
		wp = 1'b1;
		hold = 1'b1;
	end

	// released lane 1 shows the inverse of the last device value so stale data never matches; lanes 0, 2, 3 show the master's own drive
	assign pins_o[0] = dev_oe_i[0] ? dev_i[0] : d0;
	assign pins_o[1] = dev_oe_i[1] ? dev_i[1] : ~dev_i[1];
	assign pins_o[2] = dev_oe_i[2] ? dev_i[2] : wp;
	assign pins_o[3] = dev_oe_i[3] ? dev_i[3] : hold;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic sel();
		sclk_o = mode3;
		tick(HALF);
		cs_n_o = 1'b0;
		tick(HALF);
	endtask

	task automatic desel();
		sclk_o = mode3;
		tick(HALF);
		cs_n_o = 1'b1;
		tick(HALF);
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o = 1'b0;
			d0 = tx[i];
			tick(HALF);
			sclk_o = 1'b1;
			rx[i] = pins_o[1];
			tick(HALF);
		end
	endtask

	// pause with the clock low; clock pulses inside must be ignored
	task automatic pause(output logic [3:0] oe);
		sclk_o = 1'b0;
		tick(HALF);
		hold = 1'b0;
		tick(HALF);
		repeat (2) begin
			sclk_o = 1'b1;
			tick(HALF);
			sclk_o = 1'b0;
			tick(HALF);
		end
		oe = dev_oe_i;
		hold = 1'b1;
		tick(HALF);
	endtask
endmodule // sfspi_spi_master

// ### tb/sfspi_front_end_tb.sv
// self-checking bench for the serial flash bus front end
`timescale 1ns/1ps
module sfspi_front_end_tb;
	import sfspi_pkg::*;
	localparam int PUW = 400;
	localparam int HALF = 8;
	logic       clk_sys_i;
	logic       rst_n_i;
	logic       cs_n;
	logic       sclk;
	logic [3:0] pins;
	logic [3:0] lane_o;
	logic [3:0] lane_oe_o;
	logic [23:0] addr_o;
	logic [7:0] wdata_o;
	logic       wdata_valid_o;
	logic       op_start_o;
	logic [7:0] op_code_o;
	logic       busy_o;
	logic [7:0] v;
	logic [3:0] oe;
	int         fail_count;
	int         total_checks;
	int         wv_cnt;
	int         os_cnt;
	logic [7:0] wv_last;

	sfspi_front_end #(.PUW_CYCLES(PUW), .OP_CYCLES(400), .ADDR_BITS(ADDR_W)) u_sfspi_front_end (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.lane_i(pins), .lane_o(lane_o), .lane_oe_o(lane_oe_o), .addr_o(addr_o),
		.array_data_i(8'h3c), .wdata_o(wdata_o), .wdata_valid_o(wdata_valid_o),
		.op_start_o(op_start_o), .op_code_o(op_code_o), .busy_o(busy_o));

	sfspi_spi_master #(.HALF(HALF)) m (
		.clk_sys_i(clk_sys_i), .dev_i(lane_o), .dev_oe_i(lane_oe_o),
		.cs_n_o(cs_n), .sclk_o(sclk), .pins_o(pins));

	initial clk_sys_i = 1'b0;
	always #5 clk_sys_i = ~clk_sys_i;

	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge clk_sys_i) begin
		if (wdata_valid_o === 1'b1) begin
			wv_cnt++;
			wv_last = wdata_o;
		end
		if (op_start_o === 1'b1)
			os_cnt++;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_o !== 1'b0 && n < 1000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (busy_o !== 1'b0) begin
			fail_count++;
			$display("ERROR busy_o expected 0 seen timeout");
			print_verdict();
		end
		#1;
	endtask

	task automatic do_reset();
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
	endtask

	task automatic cmd(input logic [7:0] op);
		m.sel();
		m.xfer(op, v);
		m.desel();
	endtask

	task automatic rd(input logic [7:0] op, output logic [7:0] r);
		m.sel();
		m.xfer(op, r);
		m.xfer(8'h00, r);
		m.desel();
	endtask

	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		cmd(OP_WREN);
		m.sel();
		m.xfer(OP_WRSR, v);
		m.xfer(lo, v);
		m.xfer(hi, v);
		m.desel();
		wait_idle();
	endtask

	// n_exp is 1 when the program must run, 0 when it must be refused
	task automatic pp(input logic [23:0] a, input logic [7:0] n_exp);
		int os0;
		int wv0;
		os0 = os_cnt;
		wv0 = wv_cnt;
		cmd(OP_WREN);
		m.sel();
		m.xfer(OP_PP, v);
		for (int i = 2; i >= 0; i--)
			m.xfer(a[i*8 +: 8], v);
		m.xfer(8'ha5, v);
		m.desel();
		check("wdata pulses", 8'(wv_cnt - wv0), n_exp);
		check("op_start pulses", 8'(os_cnt - os0), n_exp);
		check("busy_o", {7'h0, busy_o}, n_exp);
		if (n_exp == 8'h01) begin
			check("wdata_o", wv_last, 8'ha5);
			rd(OP_RDSR1, v);
			check("busy and latch", v & 8'h03, 8'h03);
		end
		wait_idle();
		cmd(OP_WRDI);
	endtask

	task automatic fread(input logic [7:0] op, input logic [3:0] exp);
		m.sel();
		m.xfer(op, v);
		repeat (4) m.xfer(8'h00, v);
		m.sclk_o = 1'b0;
		m.tick(HALF);
		check("lane_oe_o", {4'h0, lane_oe_o}, {4'h0, exp});
		check("op_code_o", op_code_o, op);
		m.desel();
	endtask

	initial begin
		fail_count = 0;
		total_checks = 0;
		wv_cnt = 0;
		os_cnt = 0;
		wv_last = 8'h00;
		do_reset();
		cmd(OP_WREN);
		rd(OP_RDSR1, v);
		check("status_low early", v, 8'h00);
		rd(OP_RDSR2, v);
		check("status_high", v, 8'h00);
		check("lane_oe_o idle", {4'h0, lane_oe_o}, 8'h00);
		m.tick(PUW);
		cmd(OP_WREN);
		rd(OP_RDSR1, v);
		check("status_low wren", v, 8'h01 << ST_WL);
		m.sel();
		m.xfer(OP_RDSR1, v);
		m.pause(oe);
		check("lane_oe_o paused", {4'h0, oe}, 8'h00);
		m.xfer(8'h00, v);
		m.desel();
		check("status resumed", v, 8'h01 << ST_WL);
		cmd(OP_WRDI);
		rd(OP_RDSR1, v);
		check("status_low wrdi", v, 8'h00);
		m.mode3 = 1'b1;
		cmd(OP_WREN);
		rd(OP_RDSR1, v);
		check("status_low mode3", v, 8'h01 << ST_WL);
		cmd(OP_WRDI);
		m.mode3 = 1'b0;
		$display("test power_up_latch_pause done");
		pp(24'h000100, 8'h01);
		rd(OP_RDSR1, v);
		check("status after program", v, 8'h00);
		cmd(OP_PD);
		cmd(OP_WREN);
		cmd(OP_RPD);
		rd(OP_RDSR1, v);
		check("status after power-down", v, 8'h00);
		$display("test program_power_down done");
		wrsr(8'h1c, 8'h00);
		rd(OP_RDSR1, v);
		check("range all", v, 8'h1c);
		pp(24'h000100, 8'h00);
		wrsr(8'h64, 8'h00);
		pp(24'h000000, 8'h00);
		pp(24'h001000, 8'h01);
		wrsr(8'h44, 8'h00);
		pp(24'h000000, 8'h01);
		wrsr(8'h24, 8'h00);
		pp(24'h001000, 8'h00);
		cmd(OP_WREN);
		cmd(OP_CE1);
		check("busy_o erase protected", {7'h0, busy_o}, 8'h00);
		cmd(OP_WRDI);
		$display("test protection done");
		m.sel();
		m.xfer(OP_READ, v);
		m.xfer(8'h00, v);
		m.xfer(8'h01, v);
		m.xfer(8'h23, v);
		m.xfer(8'h00, v);
		check("array read", v, 8'h3c);
		check("addr_o", addr_o[7:0], 8'h24);
		m.desel();
		fread(OP_RDSR1, OE_1);
		fread(OP_DOUT, OE_2);
		fread(OP_QOUT, 4'h0);
		wrsr(8'h00, 8'h01 << SH_QE);
		rd(OP_RDSR2, v);
		check("quad enable", v, 8'h01 << SH_QE);
		cmd(OP_WREN);
		cmd(OP_CE2);
		check("busy_o erase", {7'h0, busy_o}, 8'h01);
		wait_idle();
		rd(OP_RDSR1, v);
		check("latch after erase", v, 8'h00);
		fread(OP_QOUT, OE_4);
		wrsr(8'h80, 8'h01 << SH_QE);
		m.wp = 1'b0;
		wrsr(8'h00, 8'h00);
		rd(OP_RDSR1, v);
		check("protect pin ignored", v, 8'h00);
		$display("test lanes done");
		wrsr(8'h80, 8'h00);
		wrsr(8'h00, 8'h00);
		rd(OP_RDSR1, v);
		check("lock pin low", v & 8'hfc, 8'h80);
		m.wp = 1'b1;
		wrsr(8'h00, 8'h00);
		rd(OP_RDSR1, v);
		check("lock pin high", v, 8'h00);
		wrsr(8'h00, 8'h01 << SH_LKHI);
		wrsr(8'h00, 8'h00);
		rd(OP_RDSR2, v);
		check("lock down", v, 8'h01 << SH_LKHI);
		do_reset();
		rd(OP_RDSR2, v);
		check("lock after power cycle", v, 8'h00);
		$display("test lock done");
		print_verdict();
	end
endmodule // sfspi_front_end_tb
